// file: logic/glpe_defines.svh
// Register indices, field positions, reset values and time-base units
`ifndef GLPE_DEFINES_SVH
`define GLPE_DEFINES_SVH

// Register indices; byte address is four times the index
`define GLPE_IDX_P0_LL   8'h4f
`define GLPE_IDX_P0_LH   8'h50
`define GLPE_IDX_P1_LL   8'h51
`define GLPE_IDX_P1_LH   8'h52
`define GLPE_IDX_CTRL    8'h60

// Field positions inside a level configuration word
`define GLPE_TB_MSB      15
`define GLPE_TB_LSB      14
`define GLPE_HC_MSB      13
`define GLPE_HC_LSB      7
`define GLPE_LC_MSB      6
`define GLPE_LC_LSB      0

// Pin control register bits
`define GLPE_CTRL_DIR0   0
`define GLPE_CTRL_DIR1   1
`define GLPE_CTRL_DAT0   2
`define GLPE_CTRL_DAT1   3

// Reset values and writable masks
`define GLPE_LL_RST      16'h007f
`define GLPE_LH_RST      16'h3f80
`define GLPE_LH_MASK     16'h3fff
`define GLPE_CTRL_RST    4'h0

// Time-base units in master-clock periods
`define GLPE_TB_UNIT0    11'h010
`define GLPE_TB_UNIT1    11'h040
`define GLPE_TB_UNIT2    11'h100
`define GLPE_TB_UNIT3    11'h400

`endif

// file: logic/glpe_pkg.sv
// Types and a helper function shared by the PWM level encoder
`default_nettype none
`include "glpe_defines.svh"
package glpe_pkg;

  typedef logic [1:0]  glpe_tb_t;
  typedef logic [6:0]  glpe_count_t;
  typedef logic [15:0] glpe_cfg_t;

  // State of one pin engine
  typedef struct packed {
    glpe_tb_t    tb_l;
    glpe_count_t hc_l;
    glpe_count_t lc_l;
    logic        phase_hi;
    glpe_count_t unit_cnt;
    logic [9:0]  pre_cnt;
    logic        out;
  } glpe_eng_t;

  // State of the register file and bus slave
  typedef struct packed {
    glpe_cfg_t   p0_ll;
    glpe_cfg_t   p0_lh;
    glpe_cfg_t   p1_ll;
    glpe_cfg_t   p1_lh;
    logic [3:0]  ctrl;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] rdata;
    logic        hready;
    logic        hresp;
  } glpe_regs_t;

  // Length of one time-base unit in clock periods
  function automatic logic [10:0] glpe_unit_len(input glpe_tb_t sel);
    logic [10:0] len;
    len = `GLPE_TB_UNIT0;
    unique case (sel)
      2'b00: len = `GLPE_TB_UNIT0;
      2'b01: len = `GLPE_TB_UNIT1;
      2'b10: len = `GLPE_TB_UNIT2;
      2'b11: len = `GLPE_TB_UNIT3;
    endcase
    return len;
  endfunction : glpe_unit_len

endpackage : glpe_pkg
`default_nettype wire

// file: logic/glpe_pwm_engine.sv
// One pin's PWM engine: time-base prescaler and high/low phase counters
`timescale 1ns/1ps
`default_nettype none
module glpe_pwm_engine (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  input  wire logic              enable_i,
  input  wire glpe_pkg::glpe_tb_t    tb_sel_i,
  input  wire glpe_pkg::glpe_count_t high_cnt_i,
  input  wire glpe_pkg::glpe_count_t low_cnt_i,
  output logic                   pin_o
);
  import glpe_pkg::*;

  localparam glpe_eng_t ENG_RST = '{tb_l: 2'h0, hc_l: 7'h00, lc_l: 7'h00,
    phase_hi: 1'b1, unit_cnt: 7'h00, pre_cnt: 10'h000, out: 1'b0};

  glpe_eng_t st;
  glpe_eng_t nxt;
  logic      tick;
  logic      boundary;

  // Period sequencing: high phase, then low phase, reload at the boundary
  always_comb begin
    nxt      = st;
    tick     = (st.pre_cnt == 10'(glpe_unit_len(st.tb_l) - 11'h001));
    boundary = 1'b0;
    if (!enable_i) begin
      nxt.pre_cnt = 10'h000;
      boundary    = 1'b1;
    end else if (tick) begin
      nxt.pre_cnt = 10'h000;
      if (st.hc_l == 7'h00 || st.lc_l == 7'h00) begin
        boundary = 1'b1; // Static level, re-evaluated every unit
      end else if (st.phase_hi) begin
        if (st.unit_cnt == st.hc_l - 7'h01) begin
          nxt.phase_hi = 1'b0;
          nxt.unit_cnt = 7'h00;
        end else begin
          nxt.unit_cnt = st.unit_cnt + 7'h01;
        end
      end else begin
        if (st.unit_cnt == st.lc_l - 7'h01) begin
          boundary = 1'b1;
        end else begin
          nxt.unit_cnt = st.unit_cnt + 7'h01;
        end
      end
    end else begin
      nxt.pre_cnt = st.pre_cnt + 10'h001;
    end
    if (boundary) begin
      nxt.tb_l     = tb_sel_i;
      nxt.hc_l     = high_cnt_i;
      nxt.lc_l     = low_cnt_i;
      nxt.phase_hi = 1'b1;
      nxt.unit_cnt = 7'h00;
    end
    // Zero high count wins over zero low count
    nxt.out = enable_i && (nxt.hc_l != 7'h00) &&
      (nxt.lc_l == 7'h00 || nxt.phase_hi);
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st <= ENG_RST;
    end else if (ce_i) begin
      st <= nxt;
    end
  end

  assign pin_o = st.out;

  // Run-length helpers for the timing checks
  logic [17:0] hi_run_ff;
  logic [17:0] lo_run_ff;
  logic        seen_ff;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      hi_run_ff <= 18'h0_0000;
      lo_run_ff <= 18'h0_0000;
      seen_ff   <= 1'b0;
    end else if (ce_i) begin
      hi_run_ff <= st.out ? hi_run_ff + 18'h0_0001 : 18'h0_0000;
      lo_run_ff <= st.out ? 18'h0_0000 : lo_run_ff + 18'h0_0001;
      // Armed only after a full high run; a truncated first run is skipped
      if (!enable_i || st.hc_l == 7'h00 || st.lc_l == 7'h00) begin
        seen_ff <= 1'b0;
      end else if (!st.out && hi_run_ff != 18'h0_0000) begin
        seen_ff <= 1'b1;
      end
    end
  end

  a_high_time: assert property (
    @(posedge clk_sys_i) disable iff (reset_i || !ce_i)
    (seen_ff && enable_i && $past(enable_i) && $fell(st.out)) |->
      hi_run_ff == 18'(st.hc_l) * 18'(glpe_unit_len(st.tb_l)))
    else $error("high phase length wrong");

  a_low_time: assert property (
    @(posedge clk_sys_i) disable iff (reset_i || !ce_i)
    ($past(seen_ff) && $past(st.lc_l) != 7'h00 && $past(enable_i) &&
     $rose(st.out)) |->
      lo_run_ff == 18'($past(st.lc_l)) * 18'(glpe_unit_len($past(st.tb_l))))
    else $error("low phase length wrong");

  a_static_low: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (st.hc_l == 7'h00) |-> !pin_o)
    else $error("zero high count must give low");

  a_static_high: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (enable_i && st.hc_l != 7'h00 && st.lc_l == 7'h00 &&
     $past(enable_i)) |-> pin_o)
    else $error("zero low count must give high");

  a_off_low: assert property (
    @(posedge clk_sys_i) disable iff (reset_i || !ce_i)
    !enable_i |=> !pin_o)
    else $error("input pin must not toggle");

  c_toggle: cover property (
    @(posedge clk_sys_i) disable iff (reset_i)
    seen_ff && $fell(st.out));

endmodule : glpe_pwm_engine
`default_nettype wire

// file: logic/glpe_encoder_top.sv
// Two-pin PWM level encoder with its AHB-Lite register file
`timescale 1ns/1ps
`default_nettype none
`include "glpe_defines.svh"
module glpe_encoder_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic                   general_pin_0_o,
  output logic                   general_pin_0_oe_o,
  output logic                   general_pin_1_o,
  output logic                   general_pin_1_oe_o
);
  import glpe_pkg::*;

  // Index decode needs haddr bits 9:2
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must lie between 10 and 32");
  end

  localparam glpe_regs_t REGS_RST = '{
    p0_ll:   `GLPE_LL_RST,
    p0_lh:   `GLPE_LH_RST,
    p1_ll:   `GLPE_LL_RST,
    p1_lh:   `GLPE_LH_RST,
    ctrl:    `GLPE_CTRL_RST,
    wr_pend: 1'b0,
    wr_idx:  8'h00,
    rdata:   32'h0000_0000,
    hready:  1'b1,
    hresp:   1'b0
  };

  glpe_regs_t  st;
  glpe_regs_t  nxt;
  logic        take;
  logic [7:0]  addr_idx;
  logic [31:0] rd_word;
  logic        pin0_lvl;
  logic        pin1_lvl;
  glpe_cfg_t   sel0_cfg;
  glpe_cfg_t   sel1_cfg;

  // Address decode of the AHB address phase
  assign take     = hsel_i && hready_i && htrans_i[1];
  assign addr_idx = haddr_i[9:2];

  // Register file: write data phase, then next address phase
  always_comb begin
    nxt     = st;
    rd_word = 32'h0000_0000;
    if (st.wr_pend) begin
      case (st.wr_idx)
        `GLPE_IDX_P0_LL: nxt.p0_ll = hwdata_i[15:0];
        `GLPE_IDX_P0_LH: nxt.p0_lh = hwdata_i[15:0] & `GLPE_LH_MASK;
        `GLPE_IDX_P1_LL: nxt.p1_ll = hwdata_i[15:0];
        `GLPE_IDX_P1_LH: nxt.p1_lh = hwdata_i[15:0] & `GLPE_LH_MASK;
        `GLPE_IDX_CTRL:  nxt.ctrl  = hwdata_i[3:0];
        default:         nxt.ctrl  = st.ctrl;
      endcase
    end
    nxt.wr_pend = take && hwrite_i;
    nxt.wr_idx  = take ? addr_idx : st.wr_idx;
    // Read data from the updated copy so a write just ahead is seen
    case (addr_idx)
      `GLPE_IDX_P0_LL: rd_word = {16'h0000, nxt.p0_ll};
      `GLPE_IDX_P0_LH: rd_word = {16'h0000, nxt.p0_lh};
      `GLPE_IDX_P1_LL: rd_word = {16'h0000, nxt.p1_ll};
      `GLPE_IDX_P1_LH: rd_word = {16'h0000, nxt.p1_lh};
      `GLPE_IDX_CTRL:  rd_word = {26'h000_0000, pin1_lvl, pin0_lvl, nxt.ctrl};
      default:         rd_word = 32'h0000_0000;
    endcase
    if (take && !hwrite_i) begin
      nxt.rdata = rd_word;
    end
    nxt.hready = 1'b1;
    nxt.hresp  = 1'b0;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st <= REGS_RST;
    end else if (ce_i) begin
      st <= nxt;
    end
  end

  // Level choice: output-data bit selects which config gives the engine its high and low counts
  always_comb begin
    sel0_cfg = st.ctrl[`GLPE_CTRL_DAT0] ? st.p0_lh : st.p0_ll;
    sel1_cfg = st.ctrl[`GLPE_CTRL_DAT1] ? st.p1_lh : st.p1_ll;
  end

  // Pin 0 engine; time base always from its low-level config
  glpe_pwm_engine u_pin0 (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .enable_i   (st.ctrl[`GLPE_CTRL_DIR0]),
    .tb_sel_i   (st.p0_ll[`GLPE_TB_MSB:`GLPE_TB_LSB]),
    .high_cnt_i (sel0_cfg[`GLPE_HC_MSB:`GLPE_HC_LSB]),
    .low_cnt_i  (sel0_cfg[`GLPE_LC_MSB:`GLPE_LC_LSB]),
    .pin_o      (pin0_lvl)
  );

  // Pin 1 engine
  glpe_pwm_engine u_pin1 (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .enable_i   (st.ctrl[`GLPE_CTRL_DIR1]),
    .tb_sel_i   (st.p1_ll[`GLPE_TB_MSB:`GLPE_TB_LSB]),
    .high_cnt_i (sel1_cfg[`GLPE_HC_MSB:`GLPE_HC_LSB]),
    .low_cnt_i  (sel1_cfg[`GLPE_LC_MSB:`GLPE_LC_LSB]),
    .pin_o      (pin1_lvl)
  );

  // Outputs straight from flip-flops
  assign hrdata_o           = st.rdata;
  assign hreadyout_o        = st.hready;
  assign hresp_o            = st.hresp;
  assign general_pin_0_o    = pin0_lvl;
  assign general_pin_1_o    = pin1_lvl;
  assign general_pin_0_oe_o = st.ctrl[`GLPE_CTRL_DIR0];
  assign general_pin_1_oe_o = st.ctrl[`GLPE_CTRL_DIR1];

  // Checks on the register file and pin control
  a_reset_values: assert property (
    @(posedge clk_sys_i)
    reset_i |=> (st.p0_ll == `GLPE_LL_RST &&
      st.p1_ll == `GLPE_LL_RST && st.p0_lh == `GLPE_LH_RST &&
      st.p1_lh == `GLPE_LH_RST && st.ctrl == `GLPE_CTRL_RST))
    else $error("reset values wrong");

  a_hilevel_reset: assert property (
    @(posedge clk_sys_i)
    reset_i |=> (st.p1_lh[`GLPE_HC_MSB:`GLPE_HC_LSB] == 7'h7f &&
      st.p1_lh[`GLPE_LC_MSB:`GLPE_LC_LSB] == 7'h00))
    else $error("high-level config reset wrong");

  a_write_lands: assert property (
    @(posedge clk_sys_i) disable iff (reset_i || !ce_i)
    (st.wr_pend && st.wr_idx == `GLPE_IDX_P1_LL) |=>
      st.p1_ll == $past(hwdata_i[15:0]))
    else $error("write to low-level config lost");

  a_read_back: assert property (
    @(posedge clk_sys_i) disable iff (reset_i || !ce_i)
    (take && !hwrite_i && !st.wr_pend && addr_idx == `GLPE_IDX_P1_LH)
      |=> hrdata_o == {16'h0000, $past(st.p1_lh)})
    else $error("read data wrong");

  a_lh_reserved: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (st.p0_lh[15:14] == 2'b00 && st.p1_lh[15:14] == 2'b00))
    else $error("reserved bits not zero");

  a_input_quiet: assert property (
    @(posedge clk_sys_i) disable iff (reset_i || !ce_i)
    (!st.ctrl[`GLPE_CTRL_DIR1] ##1 !st.ctrl[`GLPE_CTRL_DIR1]) |->
      !general_pin_1_o && !general_pin_1_oe_o)
    else $error("input pin driven");

  a_level_pick: assert property (
    @(posedge clk_sys_i) disable iff (reset_i || !ce_i)
    (st.ctrl[`GLPE_CTRL_DIR0] && st.ctrl[`GLPE_CTRL_DAT0] &&
     u_pin0.boundary) |=>
      (u_pin0.st.hc_l == $past(st.p0_lh[`GLPE_HC_MSB:`GLPE_HC_LSB]) &&
       u_pin0.st.lc_l == $past(st.p0_lh[`GLPE_LC_MSB:`GLPE_LC_LSB])))
    else $error("high level must load high-level counts");

  a_bus_okay: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    hreadyout_o && !hresp_o)
    else $error("slave must answer OKAY at once");

  c_write_cfg: cover property (
    @(posedge clk_sys_i) disable iff (reset_i)
    st.wr_pend && st.wr_idx == `GLPE_IDX_P0_LL);

  c_read_ctrl: cover property (
    @(posedge clk_sys_i) disable iff (reset_i)
    take && !hwrite_i && addr_idx == `GLPE_IDX_CTRL);

  c_pin_high: cover property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $rose(general_pin_1_o));

endmodule : glpe_encoder_top
`default_nettype wire

// file: bench/glpe_pin_watch.sv
// Far-side observer that measures the runs of one encoded pin
`timescale 1ns/1ps
`default_nettype none
module glpe_pin_watch (
  input  wire logic        clk_sys_i,
  input  wire logic        pin_i,
  output logic [15:0]      hi_len_o,
  output logic [15:0]      lo_len_o,
  output logic [15:0]      edges_o
);
  logic        last_ff = 1'b0;
  logic [15:0] run_ff  = 16'h0001;
  logic [15:0] hi_ff   = 16'h0000;
  logic [15:0] lo_ff   = 16'h0000;
  logic [15:0] edge_ff = 16'h0000;

  // Store the length of each finished high or low run
  always_ff @(posedge clk_sys_i) begin
    last_ff <= pin_i;
    if (pin_i !== last_ff) begin
      run_ff  <= 16'h0001;
      edge_ff <= edge_ff + 16'h0001;
      if (last_ff === 1'b1) begin
        hi_ff <= run_ff;
      end else begin
        lo_ff <= run_ff;
      end
    end else begin
      run_ff <= run_ff + 16'h0001;
    end
  end

  // Measured values go out as they are
  assign hi_len_o = hi_ff;
  assign lo_len_o = lo_ff;
  assign edges_o  = edge_ff;
endmodule : glpe_pin_watch
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the two-pin PWM level encoder
`timescale 1ns/1ps
`default_nettype none
`include "glpe_defines.svh"
module testbench;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        ce        = 1'b1;
  logic        hsel      = 1'b0;
  logic [11:0] haddr     = 12'h000;
  logic [1:0]  htrans    = 2'b00;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        pin0;
  logic        oe0;
  logic        pin1;
  logic        oe1;
  logic [15:0] hi0;
  logic [15:0] lo0;
  logic [15:0] ed0;
  logic [15:0] hi1;
  logic [15:0] lo1;
  logic [15:0] ed1;
  int          err_total   = 0;
  int          check_count = 0;
  int          unit_len [4] = '{16, 64, 256, 1024};

  // Device under test, bus hready looped back from the one slave
  glpe_encoder_top dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .general_pin_0_o(pin0), .general_pin_0_oe_o(oe0),
    .general_pin_1_o(pin1), .general_pin_1_oe_o(oe1)
  );

  // Far-side observers, one per pin
  glpe_pin_watch watch0 (.clk_sys_i(clk_sys_i), .pin_i(pin0),
    .hi_len_o(hi0), .lo_len_o(lo0), .edges_o(ed0));
  glpe_pin_watch watch1 (.clk_sys_i(clk_sys_i), .pin_i(pin1),
    .hi_len_o(hi1), .lo_len_o(lo1), .edges_o(ed1));

  // Clock of 25 ns period
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One single AHB-Lite word transfer, waiting on hready each phase
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys_i);
    hsel   <= 1'b1;
    haddr  <= {2'b00, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    chk("hready", 32'h0000_0001, {31'h0, hready});
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] idx,
                       input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, idx, 32'h0000_0000, x);
    chk(what, exp, x);
  endtask : rdchk

  // Reset values and an unmapped place
  task automatic t_reset();
    rdchk("p0_ll", `GLPE_IDX_P0_LL, 32'h0000_007f);
    rdchk("p0_lh", `GLPE_IDX_P0_LH, 32'h0000_3f80);
    rdchk("p1_ll", `GLPE_IDX_P1_LL, 32'h0000_007f);
    rdchk("p1_lh", `GLPE_IDX_P1_LH, 32'h0000_3f80);
    rdchk("unmapped", 8'h70, 32'h0000_0000);
  endtask : t_reset

  // Field masks: time base only in the low-level word
  task automatic t_regs();
    wr(`GLPE_IDX_P1_LH, 32'hffff_ffff);
    rdchk("p1_lh mask", `GLPE_IDX_P1_LH, 32'h0000_3fff);
    wr(`GLPE_IDX_P1_LL, 32'h0000_ffff);
    rdchk("p1_ll full", `GLPE_IDX_P1_LL, 32'h0000_ffff);
    wr(8'h70, 32'h0000_1234);
    rdchk("unmapped wr", 8'h70, 32'h0000_0000);
  endtask : t_regs

  // Toggling waveform: measure full high and low runs
  task automatic t_pwm(input logic p, input logic [15:0] ll,
                       input logic [15:0] lh, input logic [3:0] ctl,
                       input int h, input int l, input int u);
    wr(p ? `GLPE_IDX_P1_LL : `GLPE_IDX_P0_LL, {16'h0000, ll});
    wr(p ? `GLPE_IDX_P1_LH : `GLPE_IDX_P0_LH, {16'h0000, lh});
    wr(`GLPE_IDX_CTRL, {28'h000_0000, ctl});
    repeat (4 * (h + l) * u + 200) @(posedge clk_sys_i);
    chk("high run", h * u, {16'h0000, p ? hi1 : hi0});
    chk("low run", l * u, {16'h0000, p ? lo1 : lo0});
    chk("oe", 32'h0000_0001, {31'h0, p ? oe1 : oe0});
  endtask : t_pwm

  // Steady level on pin 0: no edges over a long window
  task automatic t_flat(input logic [7:0] idx, input logic [15:0] cfg,
                        input logic [3:0] ctl, input logic lvl);
    logic [15:0] e;
    wr(idx, {16'h0000, cfg});
    wr(`GLPE_IDX_CTRL, {28'h000_0000, ctl});
    repeat (3200) @(posedge clk_sys_i);
    e = ed0;
    repeat (400) @(posedge clk_sys_i);
    chk("edges", {16'h0000, e}, {16'h0000, ed0});
    chk("level", {31'h0, lvl}, {31'h0, pin0});
    chk("oe", {31'h0, ctl[0]}, {31'h0, oe0});
    rdchk("ctrl", `GLPE_IDX_CTRL, {26'h000_0000, 1'b0, lvl, ctl});
  endtask : t_flat

  // Clock enable low freezes the running waveform on pin 1
  task automatic t_freeze();
    logic [15:0] e;
    logic        v;
    @(posedge clk_sys_i);
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    e = ed1;
    v = pin1;
    repeat (200) @(posedge clk_sys_i);
    chk("frozen edges", {16'h0000, e}, {16'h0000, ed1});
    chk("frozen level", {31'h0, v}, {31'h0, pin1});
    ce <= 1'b1;
  endtask : t_freeze

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_reset();
    t_regs();
    for (int k = 0; k < 4; k++) begin
      t_pwm(1'b0, {k[1:0], 7'h01, 7'h02}, 16'h3f80, 4'b0001,
            1, 2, unit_len[k]);
    end
    t_pwm(1'b1, 16'h0000, {2'b00, 7'h03, 7'h01}, 4'b1010,
          3, 1, 16);
    t_freeze();
    t_flat(`GLPE_IDX_P0_LL, {2'b00, 7'h00, 7'h05}, 4'b0001, 1'b0);
    t_flat(`GLPE_IDX_P0_LL, 16'h0000, 4'b0001, 1'b0);
    t_flat(`GLPE_IDX_P0_LH, {2'b00, 7'h05, 7'h00}, 4'b0101, 1'b1);
    t_flat(`GLPE_IDX_P0_LL, {2'b00, 7'h01, 7'h01}, 4'b0100, 1'b0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
